// ===== rtl/ptk_regs.svh
// register offsets, field positions and codes of the two-way page table keeper
`ifndef PTK_REGS_SVH
`define PTK_REGS_SVH
// ==========================================
// register byte offsets
`define PTK_CTRL     8'h00
`define PTK_PCOND    8'h04
`define PTK_PSETUP   8'h08
`define PTK_MCMD     8'h0C
`define PTK_VADDR    8'h10
`define PTK_ACC_LO   8'h14
`define PTK_ACC_HI   8'h18
`define PTK_AR_LO    8'h1C
`define PTK_AR_HI    8'h20
`define PTK_MAPPTR   8'h24
`define PTK_STATUS   8'h28
`define PTK_ID       8'h2C
`define PTK_PF_LO    8'h30
`define PTK_PF_HI    8'h34
// ==========================================
// field positions (36-bit words: doc bit n sits at index 35-n)
`define PTK_CTRL_USER   0
`define PTK_CTRL_KMODE  1
`define PTK_PCOND_EN    0
`define PTK_PSETUP_KEEP 0
`define PTK_MC_COND     9
`define PTK_PTR_KEEP    5
`define PTK_W_USER      35
`define PTK_W_BIT01     34
`define PTK_W_BIT02     33
`define PTK_W_MOD       32
`define PTK_W_WRT       31
`define PTK_W_PUB       29
`define PTK_W_CACHE     28
`define PTK_W_KEEP      27
`define PTK_AR_A        35
`define PTK_AR_P        34
`define PTK_AR_W        33
`define PTK_AR_S        32
`define PTK_AR_C        31
`define PTK_AR_KEEP     12
`define PTK_ID_KEEP     12
`define PTK_ST_REFILL   0
`define PTK_ST_PFAIL    1
`define PTK_ST_IOPF     2
`define PTK_ST_EN       3
`define PTK_ST_BUSY     4
// ==========================================
// microinstruction number-field codes (octal)
`define PTK_MC_NORMAL   9'o000
`define PTK_MC_ENINV    9'o001
`define PTK_MC_ENBOTH   9'o002
`define PTK_MC_WRTB     9'o010
`define PTK_MC_WRDIR    9'o020
`define PTK_MC_INV      9'o031
`define PTK_MC_WRDIR2   9'o033
`define PTK_MC_ENINVNK  9'o041
`define PTK_MC_INVNK    9'o061
`define PTK_MC_SELBOTH  9'o070
`define PTK_MC_SEL0     9'o071
`define PTK_MC_SEL1     9'o073
`define PTK_MC_IOPF     9'o100
`define PTK_MC_PFAIL    9'o200
// ==========================================
// failure codes, trap locations, limits
`define PTK_PF_SOFT     5'o00
`define PTK_PF_PARITY   5'o25
`define PTK_PF_SECT     5'o27
`define PTK_PF_ARXPAR   5'o77
`define PTK_SECT_MAX    12'o37
`define PTK_UPT_WORD    9'o500
`define PTK_UPT_FLAGS   9'o501
`define PTK_UPT_OLDPC   9'o502
`define PTK_UPT_NEWPC   9'o503
`endif

// ===== rtl/ptk_pkg.sv
// types of the two-way page table keeper
package ptk_pkg;
    typedef enum logic [2:0] {TS_IDLE, TS_W500, TS_W501, TS_W502, TS_R503, TS_LOAD} ptk_trap_t;
    typedef logic [35:0] ptk_word_t;
endpackage

// ===== rtl/ptk_pager.sv
// two-way page table with keep flags, refill support, sweeps and page-fail trap
`timescale 1ns/1ps
`default_nettype none
`include "ptk_regs.svh"
module ptk_pager
    import ptk_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // execution unit side
    input wire logic [22:0] pc_in,
    input wire ptk_pkg::ptk_word_t flags_in,
    input wire logic arx_parity_err,
    output logic abort,
    output logic refill_trap,
    // process table access for the page-fail trap
    output logic upt_we,
    output logic upt_re,
    output logic [8:0] upt_addr,
    output ptk_pkg::ptk_word_t upt_wdata,
    input wire ptk_pkg::ptk_word_t upt_rdata,
    output logic pc_load,
    output logic [22:0] new_pc
);
    import ptk_pkg::*;
    // ==========================================
    // decode helpers
    function automatic logic mc_full(input logic [8:0] c);
        mc_full = (c == `PTK_MC_ENINV) || (c == `PTK_MC_INV);
    endfunction
    function automatic logic mc_nonkeep(input logic [8:0] c);
        mc_nonkeep = (c == `PTK_MC_ENINVNK) || (c == `PTK_MC_INVNK);
    endfunction
    function automatic logic mc_enable(input logic [8:0] c);
        mc_enable = (c == `PTK_MC_ENINV) || (c == `PTK_MC_ENBOTH) || (c == `PTK_MC_ENINVNK);
    endfunction
    // ==========================================
    // state
    logic wr_q;
    logic [7:0] wa_q;
    logic user_q, kmode_q, en_q, keep_and_q, lk_q, fix_q;
    logic [1:0] tsel_q;
    logic [3:0] acc_and_q;
    logic [29:0] va_q;
    ptk_word_t ar_q, acc_q, pf_q;
    logic st_refill_q, st_pfail_q, st_iopf_q;
    logic [19:0] tb_q [2][512];
    logic [511:0] tb_v_q [2];
    logic [511:0] dv_q [2];
    logic [9:0] dir_q [2][256];
    logic [255:0] lrr_q;
    ptk_trap_t ts_q;
    logic [22:0] old_pc_q;
    logic trig;
    // ==========================================
    // write events seen in the data phase
    logic [8:0] code;
    logic op_v, pc_wr, ps_wr, inv_all, inv_nk, dir_wr, tb_wr;
    logic [11:0] sect;
    logic [8:0] page;
    logic [7:0] pidx;
    logic wway;
    assign code = hwdata[8:0];
    assign op_v = wr_q && (wa_q == `PTK_MCMD) && hwdata[`PTK_MC_COND];
    assign pc_wr = wr_q && (wa_q == `PTK_PCOND);
    assign ps_wr = wr_q && (wa_q == `PTK_PSETUP);
    assign inv_all = pc_wr || (op_v && mc_full(code)) || (ps_wr && !hwdata[`PTK_PSETUP_KEEP]);
    assign inv_nk = (op_v && mc_nonkeep(code)) || (ps_wr && hwdata[`PTK_PSETUP_KEEP]);
    assign dir_wr = op_v && ((code == `PTK_MC_WRDIR) || (code == `PTK_MC_WRDIR2));
    assign tb_wr = op_v && (code == `PTK_MC_WRTB);
    assign sect = va_q[29:18];
    assign page = va_q[17:9];
    assign pidx = page[8:1];
    // refill goes to the least recent table unless one table is selected
    assign wway = (tsel_q == 2'b01) ? 1'b0 : (tsel_q == 2'b10) ? 1'b1 : lrr_q[pidx];
    // ==========================================
    // ahb-lite slave: zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            wr_q <= hsel && htrans[1] && hready && hwrite;
            wa_q <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hsel && htrans[1] && hready && !hwrite) begin
                case (haddr[7:0])
                    `PTK_CTRL: hrdata <= {30'h00000000, kmode_q, user_q};
                    `PTK_PCOND: hrdata <= {31'h00000000, en_q};
                    `PTK_VADDR: hrdata <= {2'h0, va_q};
                    `PTK_ACC_LO: hrdata <= acc_q[31:0];
                    `PTK_ACC_HI: hrdata <= {28'h0000000, acc_q[35:32]};
                    `PTK_AR_LO: hrdata <= ar_q[31:0];
                    `PTK_AR_HI: hrdata <= {28'h0000000, ar_q[35:32]};
                    `PTK_STATUS: hrdata <= {25'h0000000, tsel_q, (ts_q != TS_IDLE) || lk_q, en_q,
                                            st_iopf_q, st_pfail_q, st_refill_q};
                    `PTK_ID: hrdata <= 32'h00000001 << `PTK_ID_KEEP;
                    `PTK_PF_LO: hrdata <= pf_q[31:0];
                    `PTK_PF_HI: hrdata <= {28'h0000000, pf_q[35:32]};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end
    // ==========================================
    // mode, enable and table selection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            user_q <= 1'b0;
            kmode_q <= 1'b0;
            en_q <= 1'b0;
            tsel_q <= 2'b11;
        end else begin
            if (wr_q && (wa_q == `PTK_CTRL)) begin
                user_q <= hwdata[`PTK_CTRL_USER];
                kmode_q <= hwdata[`PTK_CTRL_KMODE];
            end
            if (pc_wr)
                en_q <= hwdata[`PTK_PCOND_EN];
            else if (op_v && mc_enable(code))
                en_q <= 1'b1;
            if (op_v && ((code == `PTK_MC_SELBOTH) || (code == `PTK_MC_ENBOTH)))
                tsel_q <= 2'b11;
            else if (op_v && (code == `PTK_MC_SEL0))
                tsel_q <= 2'b01;
            else if (op_v && (code == `PTK_MC_SEL1))
                tsel_q <= 2'b10;
        end
    end
    // ==========================================
    // refill word, pointer accumulation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ar_q <= 36'h000000000;
            keep_and_q <= 1'b1;
            acc_and_q <= 4'hF;
        end else if (wr_q && (wa_q == `PTK_AR_LO)) begin
            ar_q[31:0] <= hwdata;
        end else if (wr_q && (wa_q == `PTK_AR_HI)) begin
            ar_q[35:32] <= hwdata[3:0];
        end else if (wr_q && (wa_q == `PTK_MAPPTR)) begin
            keep_and_q <= keep_and_q & hwdata[`PTK_PTR_KEEP];
            ar_q[`PTK_AR_KEEP] <= keep_and_q & hwdata[`PTK_PTR_KEEP];
            acc_and_q <= acc_and_q & hwdata[4:1];
        end else if (tb_wr) begin
            keep_and_q <= 1'b1;
            acc_and_q <= 4'hF;
        end
    end
    // ==========================================
    // directory: section info and per-page valid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dv_q[0] <= '0;
            dv_q[1] <= '0;
        end else if (inv_all) begin
            for (int w = 0; w < 2; w++)
                if (pc_wr || ps_wr || tsel_q[w])
                    dv_q[w] <= '0;
        end else if (dir_wr) begin
            if (code == `PTK_MC_WRDIR2) begin
                dv_q[wway][{pidx, 1'b0}] <= 1'b1;
                dv_q[wway][{pidx, 1'b1}] <= 1'b1;
            end else begin
                dv_q[wway][page] <= 1'b1;
            end
        end
    end
    always_ff @(posedge hclk) begin
        if (dir_wr)
            dir_q[wway][pidx] <= {user_q, sect[4:0], acc_and_q};
    end
    // ==========================================
    // translation buffer valid bits and sweeps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tb_v_q[0] <= '0;
            tb_v_q[1] <= '0;
        end else if (inv_all) begin
            for (int w = 0; w < 2; w++)
                if (pc_wr || ps_wr || tsel_q[w])
                    tb_v_q[w] <= '0;
        end else if (inv_nk) begin
            for (int w = 0; w < 2; w++)
                if (ps_wr || tsel_q[w])
                    for (int i = 0; i < 512; i++)
                        if (!tb_q[w][i][1])
                            tb_v_q[w][i] <= 1'b0;
        end else if (dir_wr) begin
            tb_v_q[wway][{pidx, 1'b0}] <= 1'b0;
            tb_v_q[wway][{pidx, 1'b1}] <= 1'b0;
        end else if (tb_wr) begin
            tb_v_q[wway][page] <= 1'b1;
        end
    end
    // entry: access(5) ppn(13) keep parity
    always_ff @(posedge hclk) begin
        if (tb_wr)
            tb_q[wway][page] <= {ar_q[`PTK_AR_A], ar_q[`PTK_AR_P] & acc_and_q[3],
                                 ar_q[`PTK_AR_W] & acc_and_q[2], ar_q[`PTK_AR_S],
                                 ar_q[`PTK_AR_C] & acc_and_q[0], ar_q[30:18], ar_q[`PTK_AR_KEEP],
                                 ^{ar_q[35:18], ar_q[`PTK_AR_KEEP]}};
    end
    // ==========================================
    // least-recent-refill flags and post-sweep fixup
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lrr_q <= '0;
            fix_q <= 1'b0;
        end else begin
            fix_q <= inv_nk;
            if (tb_wr)
                lrr_q[pidx] <= ~wway;
            else if (fix_q)
                for (int i = 0; i < 256; i++)
                    if ((|tb_v_q[0][2*i +: 2]) && !(|tb_v_q[1][2*i +: 2]))
                        lrr_q[i] <= 1'b1;
                    else if ((|tb_v_q[1][2*i +: 2]) && !(|tb_v_q[0][2*i +: 2]))
                        lrr_q[i] <= 1'b0;
        end
    end
    // ==========================================
    // lookup in both tables
    logic [1:0] hit;
    logic [19:0] ent [2];
    for (genvar w = 0; w < 2; w++) begin : g_way
        assign ent[w] = tb_q[w][page];
        assign hit[w] = dv_q[w][page] && tb_v_q[w][page] && (dir_q[w][pidx][9:4] == {user_q, sect[4:0]});
    end
    logic [19:0] hent;
    logic sect_bad, par_bad;
    assign hent = hit[0] ? ent[0] : ent[1];
    assign sect_bad = sect > `PTK_SECT_MAX;
    assign par_bad = ^hent != 1'b0;
    // failure word with a given type code
    function automatic ptk_word_t pfw(input logic u, input logic [4:0] t, input logic k, input logic [21:0] a);
        pfw = {u, t, 2'b00, k, 5'b00000, a};
    endfunction
    // ==========================================
    // map instruction: write of the address starts one lookup
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            va_q <= 30'h00000000;
            lk_q <= 1'b0;
            acc_q <= 36'h000000000;
            st_refill_q <= 1'b0;
            refill_trap <= 1'b0;
        end else begin
            lk_q <= wr_q && (wa_q == `PTK_VADDR);
            refill_trap <= 1'b0;
            if (wr_q && (wa_q == `PTK_VADDR))
                va_q <= hwdata[29:0];
            if (lk_q) begin
                if (!en_q || !kmode_q)
                    acc_q <= pfw(user_q, `PTK_PF_SOFT, 1'b0, va_q[21:0]);
                else if (sect_bad)
                    acc_q <= pfw(user_q, `PTK_PF_SECT, 1'b0, va_q[21:0]);
                else if (hit == 2'b00) begin
                    acc_q <= pfw(user_q, `PTK_PF_SOFT, 1'b0, va_q[21:0]);
                    refill_trap <= 1'b1;
                end else if (par_bad)
                    acc_q <= pfw(user_q, `PTK_PF_PARITY, hent[1], va_q[21:0]);
                else
                    acc_q <= {user_q, 1'b0, 1'b1, hent[16], hent[17], 1'b0, hent[18], hent[15],
                              hent[1], 5'b00000, hent[14:2], va_q[8:0]};
            end
            if (lk_q && en_q && kmode_q && !sect_bad && (hit == 2'b00))
                st_refill_q <= 1'b1;
            else if (wr_q && (wa_q == `PTK_STATUS) && hwdata[`PTK_ST_REFILL])
                st_refill_q <= 1'b0;
        end
    end
    // ==========================================
    // failure word, error flags and trap trigger
    assign trig = (ts_q == TS_IDLE) && ((op_v && (code == `PTK_MC_PFAIL)) || (arx_parity_err && user_q));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pf_q <= 36'h000000000;
            st_pfail_q <= 1'b0;
            st_iopf_q <= 1'b0;
        end else begin
            if (trig && !(op_v && (code == `PTK_MC_PFAIL)))
                pf_q <= pfw(1'b1, `PTK_PF_ARXPAR, 1'b0, va_q[21:0]);
            else if (lk_q && (!en_q || !kmode_q || sect_bad || (hit == 2'b00) || par_bad))
                pf_q <= {1'b0, 35'h0} | pfw(user_q, sect_bad ? `PTK_PF_SECT : (hit != 2'b00) && par_bad ?
                          `PTK_PF_PARITY : `PTK_PF_SOFT, 1'b0, va_q[21:0]);
            if (trig)
                st_pfail_q <= 1'b1;
            else if (wr_q && (wa_q == `PTK_STATUS) && hwdata[`PTK_ST_PFAIL])
                st_pfail_q <= 1'b0;
            if (op_v && (code == `PTK_MC_IOPF))
                st_iopf_q <= 1'b1;
            else if (wr_q && (wa_q == `PTK_STATUS) && hwdata[`PTK_ST_IOPF])
                st_iopf_q <= 1'b0;
        end
    end
    // ==========================================
    // page-fail trap sequencer: 500 word, 501 flags, 502 old pc, read 503
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ts_q <= TS_IDLE;
            abort <= 1'b0;
            upt_we <= 1'b0;
            upt_re <= 1'b0;
            upt_addr <= 9'h000;
            upt_wdata <= 36'h000000000;
            pc_load <= 1'b0;
            new_pc <= 23'h000000;
            old_pc_q <= 23'h000000;
        end else begin
            abort <= 1'b0;
            upt_we <= 1'b0;
            upt_re <= 1'b0;
            pc_load <= 1'b0;
            case (ts_q)
                TS_IDLE: begin
                    if (trig) begin
                        abort <= 1'b1;
                        old_pc_q <= pc_in;
                        ts_q <= TS_W500;
                    end
                end
                TS_W500: begin
                    upt_we <= 1'b1;
                    upt_addr <= `PTK_UPT_WORD;
                    upt_wdata <= pf_q;
                    ts_q <= TS_W501;
                end
                TS_W501: begin
                    upt_we <= 1'b1;
                    upt_addr <= `PTK_UPT_FLAGS;
                    upt_wdata <= flags_in;
                    ts_q <= TS_W502;
                end
                TS_W502: begin
                    upt_we <= 1'b1;
                    upt_addr <= `PTK_UPT_OLDPC;
                    upt_wdata <= {13'h0000, old_pc_q};
                    ts_q <= TS_R503;
                end
                TS_R503: begin
                    upt_re <= 1'b1;
                    upt_addr <= `PTK_UPT_NEWPC;
                    ts_q <= TS_LOAD;
                end
                TS_LOAD: begin
                    pc_load <= 1'b1;
                    new_pc <= upt_rdata[22:0];
                    ts_q <= TS_IDLE;
                end
                default: ts_q <= TS_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== verification/ptk_pager_assertions.sv
// checker watching the page table keeper ports
`timescale 1ns/1ps
`default_nettype none
`include "ptk_regs.svh"
module ptk_pager_checker
    import ptk_pkg::*;
(
    // clock, reset and bus
    input wire logic hclk, hresetn, hsel, hwrite,
    input wire logic [31:0] haddr, hwdata,
    input wire logic [1:0] htrans,
    // execution unit and trap link
    input wire logic abort, refill_trap, upt_we, upt_re, pc_load,
    input wire logic [8:0] upt_addr,
    input wire ptk_pkg::ptk_word_t upt_wdata, upt_rdata,
    input wire logic [22:0] new_pc
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic mc_q, va_q;
    // flag data phases of command and address writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mc_q <= 1'b0;
            va_q <= 1'b0;
        end else begin
            mc_q <= hsel && htrans[1] && hwrite && haddr[7:0] == `PTK_MCMD;
            va_q <= hsel && htrans[1] && hwrite && haddr[7:0] == `PTK_VADDR;
        end
    end
    a_fail_aborts: assert property (mc_q && hwdata[9:0] == 10'h280 |-> ##[1:3] abort)
        else $error("page fail code did not abort");
    a_no_cond_idle: assert property (mc_q && hwdata[9:0] == 10'h080 |-> ##1 !abort [*3])
        else $error("code acted without condition");
    a_abort_single: assert property (abort |=> !abort)
        else $error("abort longer than one cycle");
    a_word_first: assert property (abort |=> upt_we && upt_addr == `PTK_UPT_WORD)
        else $error("failure word not stored after abort");
    a_trap_order: assert property (upt_we && upt_addr == `PTK_UPT_WORD |=> upt_we && upt_addr == `PTK_UPT_FLAGS
        ##1 upt_we && upt_addr == `PTK_UPT_OLDPC && upt_wdata[35:23] == 13'h0 ##1 upt_re && upt_addr == `PTK_UPT_NEWPC)
        else $error("trap locations out of order");
    a_word_zeros: assert property (upt_we && upt_addr == `PTK_UPT_WORD |-> upt_wdata[26:22] == 5'h0)
        else $error("failure word zero field set");
    a_new_pc_load: assert property (upt_re |=> pc_load && new_pc == $past(upt_rdata[22:0]))
        else $error("new pc not loaded from table");
    a_refill_cause: assert property (refill_trap |-> $past(va_q, 1) || $past(va_q, 2) || $past(va_q, 3))
        else $error("refill trap without lookup");
    a_refill_pulse: assert property (refill_trap |=> !refill_trap)
        else $error("refill trap longer than one cycle");
endmodule
bind ptk_pager ptk_pager_checker ptk_pager_checker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite),
    .haddr(haddr), .hwdata(hwdata), .htrans(htrans), .abort(abort), .refill_trap(refill_trap), .upt_we(upt_we),
    .upt_re(upt_re), .pc_load(pc_load), .upt_addr(upt_addr), .upt_wdata(upt_wdata), .upt_rdata(upt_rdata),
    .new_pc(new_pc));
`default_nettype wire

// ===== verification/ptk_upt_model.sv
// process table model answering the page-fail trap
`timescale 1ns/1ps
`default_nettype none
module ptk_upt_model
    import ptk_pkg::*;
(
    // trap link
    input wire logic hclk, upt_we, upt_re,
    input wire logic [8:0] upt_addr,
    input wire ptk_pkg::ptk_word_t upt_wdata,
    output ptk_pkg::ptk_word_t upt_rdata
);
    ptk_word_t mem [0:3];
    ptk_word_t junk = 36'h0;
    // store trap words, keep a moving pattern for idle cycles
    always @(posedge hclk) begin
        junk <= ~junk ^ 36'h5A5A5A5A5;
        if (upt_we) mem[upt_addr[1:0]] <= upt_wdata;
    end
    // addressed word while the read strobe stands, else a moving pattern
    assign upt_rdata = upt_re ? mem[upt_addr[1:0]] : junk;
endmodule
`default_nettype wire

// ===== verification/test_two_way_page_table_keep.sv
// self-checking bench of the page table keeper
`timescale 1ns/1ps
`default_nettype none
`include "ptk_regs.svh"
module test_two_way_page_table_keep;
    import ptk_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, arithmetic_extension_register = 0, rdy, hresp, abort, rtrap, we, re, pcl;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, stat;
    logic [1:0] htrans = 0;
    logic [22:0] pc_in = 0, new_pc;
    logic [8:0] ua, pg, off;
    ptk_word_t flags_in = 0, wd, rdat, acc, a0, a1, a2;
    int fail_count = 0, checks = 0, loads = 0;
    ptk_pager ptk_pager_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(rdy), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(rdy),
        .hresp(hresp), .pc_in(pc_in), .flags_in(flags_in), .arx_parity_err(arithmetic_extension_register), .abort(abort),
        .refill_trap(rtrap), .upt_we(we), .upt_re(re), .upt_addr(ua), .upt_wdata(wd), .upt_rdata(rdat),
        .pc_load(pcl), .new_pc(new_pc));
    ptk_upt_model ptk_upt_model_i (.hclk(hclk), .upt_we(we), .upt_re(re), .upt_addr(ua), .upt_wdata(wd),
        .upt_rdata(rdat));
    // clock and count of new pc loads
    initial forever #2.5 hclk = ~hclk;
    always @(posedge hclk) if (pcl === 1'b1) loads++;
    task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    // one single ahb transfer, read data left in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (rdy !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rd36(input logic [7:0] a);
        bus(0, a, 0);
        acc[31:0] = rd;
        bus(0, a + 8'h4, 0);
        acc[35:32] = rd[3:0];
    endtask
    function automatic logic [31:0] va(input logic [11:0] s);
        va = {2'h0, s, pg, off};
    endfunction
    function automatic ptk_word_t mk(input logic k);
        mk = {5'($urandom), 13'($urandom), 5'h0, k, 12'h0};
    endfunction
    function automatic ptk_word_t xl(input ptk_word_t a, input logic [8:0] o);
        xl = {3'b001, 1'b0, a[33], 1'b0, a[34], a[31], a[12], 5'h0, a[30:18], o};
    endfunction
    // lookup: clear flags, translate, spacer read, flags and result
    task automatic look(input logic [31:0] v);
        bus(1, `PTK_STATUS, 32'h7);
        bus(1, `PTK_VADDR, v);
        bus(0, `PTK_ID, 0);
        chk("id keep option", 1, rd[12]);
        bus(0, `PTK_STATUS, 0);
        stat = rd;
        rd36(`PTK_ACC_LO);
    endtask
    task automatic hit(input logic [31:0] v, input ptk_word_t a, input logic e);
        look(v);
        chk("refill flag", !e, stat[0]);
        if (e) chk("translation", xl(a, v[8:0]), acc & 36'hEFFFFFFFF);
        else chk("soft code", `PTK_PF_SOFT, acc[34:30]);
    endtask
    // refill a missing mapping through ar, pointer and codes 20, 10
    task automatic rf(input logic [31:0] v, input ptk_word_t a);
        look(v);
        if (stat[0]) begin
            bus(1, `PTK_AR_LO, a[31:0] & 32'hFFFFEFFF);
            bus(1, `PTK_AR_HI, {28'h0, a[35:32]});
            bus(1, `PTK_MAPPTR, {26'h0, a[12], 5'h1E});
            rd36(`PTK_AR_LO);
            chk("refill word", a, acc);
            bus(1, `PTK_MCMD, 32'h210);
            bus(1, `PTK_MCMD, 32'h208);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        logic [8:0] c [9];
        logic [11:0] s0;
        c = '{9'o041, 9'o061, 9'o071, 9'o073, 9'o070, 9'o002, 9'o000, 9'o031, 9'o001};
        void'($urandom(32'hC1A18BB1));
        pg = 9'($urandom);
        off = 9'($urandom);
        s0 = 12'($urandom_range(0, 9));
        a0 = mk(1);
        a1 = mk(0);
        a2 = mk(0);
        ptk_upt_model_i.mem[3] = {13'h0, 23'($urandom)};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, 8'h3C, 0);
        chk("unmapped read", 0, rd);
        chk("okay response", 0, hresp);
        bus(1, `PTK_CTRL, 2);
        bus(1, `PTK_PCOND, 1);
        rf(va(s0), a0);
        rf(va(s0 + 10), a1);
        hit(va(s0), a0, 1);
        hit(va(s0 + 10), a1, 1);
        bus(1, `PTK_PSETUP, 1);
        hit(va(s0), a0, 1);
        hit(va(s0 + 10), a1, 0);
        rf(va(s0 + 20), a2);
        hit(va(s0), a0, 1);
        hit(va(s0 + 20), a2, 1);
        bus(1, `PTK_PSETUP, 0);
        hit(va(s0), a0, 0);
        foreach (c[i]) begin
            rf(va(s0), a0);
            bus(1, `PTK_MCMD, {22'h0, 1'b1, c[i]});
            hit(va(s0), a0, !(c[i] == 9'o031 || c[i] == 9'o001));
        end
        rf(va(s0), a0);
        bus(1, `PTK_MCMD, 32'h019);
        hit(va(s0), a0, 1);
        bus(1, `PTK_PCOND, 1);
        hit(va(s0), a0, 0);
        look({2'h0, 12'o40, pg, off});
        chk("section fault", `PTK_PF_SECT, acc[34:30]);
        pc_in <= 23'($urandom);
        flags_in <= {4'h0, $urandom};
        bus(1, `PTK_MCMD, 32'h080);
        repeat (10) @(posedge hclk);
        chk("trap without condition", 0, loads);
        bus(1, `PTK_MCMD, 32'h280);
        repeat (10) @(posedge hclk);
        chk("trap taken", 1, loads);
        chk("new pc", ptk_upt_model_i.mem[3][22:0], new_pc);
        chk("old pc", pc_in, ptk_upt_model_i.mem[2]);
        chk("flags", flags_in, ptk_upt_model_i.mem[1]);
        bus(1, `PTK_MCMD, 32'h240);
        bus(0, `PTK_STATUS, 0);
        chk("fail flags", 3'h3, rd[2:1]);
        bus(1, `PTK_CTRL, 3);
        arithmetic_extension_register <= 1'b1;
        @(posedge hclk);
        arithmetic_extension_register <= 1'b0;
        repeat (10) @(posedge hclk);
        chk("parity trap", 2, loads);
        rd36(`PTK_PF_LO);
        chk("parity code", `PTK_PF_ARXPAR, acc[34:30]);
        chk("user flag", 1, acc[35]);
        chk("stored word", acc, ptk_upt_model_i.mem[0]);
        tally_and_finish();
    end
endmodule
`default_nettype wire
